//--- rtl/vtadc_defs.svh
// Offsets, field positions, reset values and timing counts of the auxiliary converter control.
`ifndef VTADC_DEFS_SVH
`define VTADC_DEFS_SVH

// Register port geometry.
`define VTADC_ADDR_W        4
`define VTADC_DATA_W        16

// Register offsets.
`define VTADC_OFS_CONFIG    4'h0
`define VTADC_OFS_MODE      4'h1
`define VTADC_OFS_FILTER    4'h2
`define VTADC_OFS_RESULT    4'h3
`define VTADC_OFS_STATUS    4'h4

// Field positions.
`define VTADC_CFG_GND_EN    7
`define VTADC_CFG_SRC_LO    0
`define VTADC_MDE_GND_RES   6
`define VTADC_MDE_RUN       0
`define VTADC_FLT_CHOP      15
`define VTADC_STA_VALID     0
`define VTADC_STA_NEW       1
`define VTADC_STA_SETTLING  2

// Reset values.
`define VTADC_CONFIG_RST    16'h0000
`define VTADC_MODE_RST      16'h0000
`define VTADC_FILTER_RST    16'h0007

// Filter codes and the rates they give.
`define VTADC_FLT_4HZ       16'hbf1d
`define VTADC_FLT_10HZ      16'h961f
`define VTADC_FLT_50HZ      16'h007f
`define VTADC_FLT_1KHZ      16'h0007
`define VTADC_FLT_8KHZ      16'h0000
`define VTADC_RATE_4_HZ     4
`define VTADC_RATE_10_HZ    10
`define VTADC_RATE_50_HZ    50
`define VTADC_RATE_1K_HZ    1000
`define VTADC_RATE_8K_HZ    8000

// System clock and conversion periods in clock cycles.
`define VTADC_CLK_HZ        25000000
`define VTADC_PER_4HZ       (`VTADC_CLK_HZ / `VTADC_RATE_4_HZ)
`define VTADC_PER_10HZ      (`VTADC_CLK_HZ / `VTADC_RATE_10_HZ)
`define VTADC_PER_50HZ      (`VTADC_CLK_HZ / `VTADC_RATE_50_HZ)
`define VTADC_PER_1KHZ      (`VTADC_CLK_HZ / `VTADC_RATE_1K_HZ)
`define VTADC_PER_8KHZ      (`VTADC_CLK_HZ / `VTADC_RATE_8K_HZ)
`define VTADC_CNT_W         24

// Conversion cycles to the first settled result after a switch.
`define VTADC_SETTLE_NOCHOP 2'h3
`define VTADC_SETTLE_CHOP   2'h2

`endif

//--- rtl/vtadc_pkg.sv
// Types shared by the auxiliary converter control.
package vtadc_pkg;
   typedef enum logic [1:0] {
      VTADC_SRC_VOLTAGE  = 2'h0,
      VTADC_SRC_EXT_TEMP = 2'h1,
      VTADC_SRC_INT_TEMP = 2'h2
   } vtadc_src_type;

   typedef enum logic [1:0] {
      VTADC_ST_IDLE     = 2'b00,
      VTADC_ST_SETTLING = 2'b01,
      VTADC_ST_SETTLED  = 2'b11
   } vtadc_state_type;
endpackage

//--- rtl/vtadc_rate.sv
// Conversion-rate divider: one tick at the end of each conversion cycle.
`timescale 1ns/1ps
`include "vtadc_defs.svh"
`default_nettype none
module vtadc_rate #(
   parameter int unsigned PER_4HZ  = `VTADC_PER_4HZ,
   parameter int unsigned PER_10HZ = `VTADC_PER_10HZ,
   parameter int unsigned PER_50HZ = `VTADC_PER_50HZ,
   parameter int unsigned PER_1KHZ = `VTADC_PER_1KHZ,
   parameter int unsigned PER_8KHZ = `VTADC_PER_8KHZ
) (
   input  wire logic   sys_clk,
   input  wire logic   rst_n,
   vtadc_tick_if.gen   tk
);
   logic [`VTADC_CNT_W-1:0] count;
   logic [`VTADC_CNT_W-1:0] last;
   logic                    tick;

   // Maps a filter code to its conversion period; unlisted codes run at 8 kHz.
   function automatic logic [`VTADC_CNT_W-1:0] period_of(input logic [15:0] code);
      case (code)
         `VTADC_FLT_4HZ:  period_of = PER_4HZ[`VTADC_CNT_W-1:0];
         `VTADC_FLT_10HZ: period_of = PER_10HZ[`VTADC_CNT_W-1:0];
         `VTADC_FLT_50HZ: period_of = PER_50HZ[`VTADC_CNT_W-1:0];
         `VTADC_FLT_1KHZ: period_of = PER_1KHZ[`VTADC_CNT_W-1:0];
         default:         period_of = PER_8KHZ[`VTADC_CNT_W-1:0];
      endcase
   endfunction

   // The last count of the cycle ends one conversion.
   assign last    = period_of(tk.rate_code) - `VTADC_CNT_W'(1);
   assign tk.tick = tick;

   // Counts clocks of one conversion cycle and pulses the tick at its end.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (!tk.run || tk.restart) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (count >= last);
         count <= (count >= last) ? '0 : count + `VTADC_CNT_W'(1);
      end
   end
endmodule
`default_nettype wire

//--- rtl/vtadc_tick_if.sv
// Link between the converter control and its conversion-rate divider.
`timescale 1ns/1ps
`default_nettype none
interface vtadc_tick_if;
   logic [15:0] rate_code;
   logic        run;
   logic        restart;
   logic        tick;
   modport ctrl (output rate_code, output run, output restart, input tick);
   modport gen  (input rate_code, input run, input restart, output tick);
endinterface
`default_nettype wire

//--- rtl/vtadc_top.sv
// Auxiliary voltage/temperature converter control with source mux, settling gate and ground switch.
`timescale 1ns/1ps
`include "vtadc_defs.svh"
`default_nettype none
// Behaviour
// - From the first clock after reset, exactly one of voltage, external temperature or internal temperature feeds the converter.
// - Sixteen-bit results are taken once per conversion cycle at 4 Hz to 8 kHz.
// - Selecting the voltage attenuator input turns its buffers on automatically.
// - With chop off, the third conversion after a source switch gives the first settled result.
// - Config bit 7 low leaves the ground switch pin floating whatever the resistor bit.
// - With ground enabled, mode bit 6 picks direct ground or the 20 kilohm path.
// - Filter codes give 4 Hz, 10 Hz, 50 Hz, 1 kHz and 8 kHz update rates.
module vtadc_top #(
   parameter int unsigned PER_4HZ  = `VTADC_PER_4HZ,
   parameter int unsigned PER_10HZ = `VTADC_PER_10HZ,
   parameter int unsigned PER_50HZ = `VTADC_PER_50HZ,
   parameter int unsigned PER_1KHZ = `VTADC_PER_1KHZ,
   parameter int unsigned PER_8KHZ = `VTADC_PER_8KHZ
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic [`VTADC_ADDR_W-1:0] reg_addr,
   input  wire logic [`VTADC_DATA_W-1:0] reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [`VTADC_DATA_W-1:0] reg_rdata,
   input  wire logic [15:0]              filter_data,
   output logic      [2:0]               source_sel,
   output logic                          atten_buf_en,
   output logic                          gnd_direct_en,
   output logic                          gnd_resistor_en,
   output logic                          run_en,
   output logic      [15:0]              result,
   output logic                          result_valid,
   output logic                          result_strobe
);
   // Link to the conversion-rate divider.
   vtadc_tick_if tk ();

   // Settings, flags and the settling sequencer state.
   logic [15:0]               converter_config_setting;
   logic [15:0]               converter_mode_setting;
   logic [15:0]               conversion_filter_setting;
   logic                      new_flag;
   logic [1:0]                settle_left;
   vtadc_pkg::vtadc_state_type state;
   vtadc_pkg::vtadc_state_type next_state;
   logic [1:0]                next_settle_left;

   // Decodes of the register port.
   wire wr_config  = reg_wr && (reg_addr == `VTADC_OFS_CONFIG);
   wire wr_mode    = reg_wr && (reg_addr == `VTADC_OFS_MODE);
   wire wr_filter  = reg_wr && (reg_addr == `VTADC_OFS_FILTER);
   wire rd_result  = reg_rd && (reg_addr == `VTADC_OFS_RESULT);
   // Source code 3 selects nothing and is refused, so from the first clock after reset the mux always has one input.
   wire [1:0] new_src = reg_wdata[`VTADC_CFG_SRC_LO +: 2];
   wire src_legal  = (new_src != 2'h3);
   wire [1:0] cur_src = converter_config_setting[`VTADC_CFG_SRC_LO +: 2];
   wire src_change = wr_config && src_legal && (new_src != cur_src);
   wire chop_on    = conversion_filter_setting[`VTADC_FLT_CHOP];
   wire running    = converter_mode_setting[`VTADC_MDE_RUN];
   wire restart    = src_change || wr_filter || (wr_mode && !running);
   // A filter write restarts with the chop setting it brings, not the one it replaces.
   wire next_chop  = wr_filter ? reg_wdata[`VTADC_FLT_CHOP] : chop_on;
   wire [1:0] settle_need = next_chop ? `VTADC_SETTLE_CHOP : `VTADC_SETTLE_NOCHOP;
   wire settled_now = (state == vtadc_pkg::VTADC_ST_SETTLED);
   // A conversion end counts only while running and not thrown away by a restart.
   wire take_result = tk.tick && !restart && running;

   // Ground switch: the enable bit gates both paths, so the pin floats while it is low.
   wire gnd_enable  = converter_config_setting[`VTADC_CFG_GND_EN];
   wire gnd_via_res = converter_mode_setting[`VTADC_MDE_GND_RES];

   // Divider control carried over the interface.
   assign tk.rate_code = conversion_filter_setting;
   assign tk.run       = running;
   assign tk.restart   = restart;

   // The divider restarts with the sequencer, so both count the same conversions.
   vtadc_rate #(
      .PER_4HZ  (PER_4HZ),
      .PER_10HZ (PER_10HZ),
      .PER_50HZ (PER_50HZ),
      .PER_1KHZ (PER_1KHZ),
      .PER_8KHZ (PER_8KHZ)
   ) u_rate (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .tk      (tk.gen)
   );

   // Settling sequencer: counts conversion cycles after a switch before results count.
   // A run bit written in this cycle is honoured at once, so a start is not lost to the stop branch.
   always_comb begin
      next_state       = state;
      next_settle_left = settle_left;
      case (state)
         vtadc_pkg::VTADC_ST_IDLE: begin
            if (running) begin
               next_state       = vtadc_pkg::VTADC_ST_SETTLING;
               next_settle_left = settle_need;
            end
         end
         vtadc_pkg::VTADC_ST_SETTLING: begin
            if (tk.tick) begin
               next_settle_left = settle_left - 2'h1;
               if (settle_left == 2'h1) begin
                  next_state = vtadc_pkg::VTADC_ST_SETTLED;
               end
            end
         end
         vtadc_pkg::VTADC_ST_SETTLED: begin
            next_state = vtadc_pkg::VTADC_ST_SETTLED;
         end
         default: begin
            next_state = vtadc_pkg::VTADC_ST_IDLE;
         end
      endcase
      if (!running && !(wr_mode && reg_wdata[`VTADC_MDE_RUN])) begin
         next_state = vtadc_pkg::VTADC_ST_IDLE;
      end else if (restart) begin
         next_state       = vtadc_pkg::VTADC_ST_SETTLING;
         next_settle_left = settle_need;
      end
   end

   // Settling state registers.
   // The count of conversions still to wait is kept beside the state.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= vtadc_pkg::VTADC_ST_IDLE;
         settle_left <= 2'h0;
      end else begin
         state       <= next_state;
         settle_left <= next_settle_left;
      end
   end

   // Software-written settings; an unused source code leaves the source unchanged.
   // The result and status offsets are read only, so writes to them are dropped.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_config_setting  <= `VTADC_CONFIG_RST;
         converter_mode_setting    <= `VTADC_MODE_RST;
         conversion_filter_setting <= `VTADC_FILTER_RST;
      end else begin
         if (wr_config) begin
            converter_config_setting <= src_legal ? reg_wdata
                                      : {reg_wdata[15:2], cur_src};
         end
         if (wr_mode) begin
            converter_mode_setting <= reg_wdata;
         end
         if (wr_filter) begin
            conversion_filter_setting <= reg_wdata;
         end
      end
   end

   // Analogue front-end controls, all registered.
   // They lag the settings by one cycle so that each front-end pin comes from a flip-flop.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         source_sel      <= 3'h0;
         atten_buf_en    <= 1'b0;
         gnd_direct_en   <= 1'b0;
         gnd_resistor_en <= 1'b0;
         run_en          <= 1'b0;
      end else begin
         source_sel      <= 3'h1 << cur_src;
         atten_buf_en    <= (cur_src == vtadc_pkg::VTADC_SRC_VOLTAGE);
         gnd_direct_en   <= gnd_enable && !gnd_via_res;
         gnd_resistor_en <= gnd_enable && gnd_via_res;
         run_en          <= running;
      end
   end

   // Result capture at each conversion end, with validity from the sequencer.
   // A new result wins over a clearing read that falls in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result        <= 16'h0000;
         result_valid  <= 1'b0;
         result_strobe <= 1'b0;
         new_flag      <= 1'b0;
      end else begin
         result_strobe <= take_result;
         if (take_result) begin
            result       <= filter_data;
            result_valid <= settled_now || (next_state == vtadc_pkg::VTADC_ST_SETTLED);
         end else if (restart || !running) begin
            result_valid <= 1'b0;
         end
         if (take_result) begin
            new_flag <= 1'b1;
         end else if (rd_result) begin
            new_flag <= 1'b0;
         end
      end
   end

   // Read data, one cycle after the read strobe; unmapped offsets read zero.
   // Reading the result offset also clears the new-result flag in the capture block.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `VTADC_OFS_CONFIG: reg_rdata <= converter_config_setting;
            `VTADC_OFS_MODE:   reg_rdata <= converter_mode_setting;
            `VTADC_OFS_FILTER: reg_rdata <= conversion_filter_setting;
            `VTADC_OFS_RESULT: reg_rdata <= result;
            `VTADC_OFS_STATUS: reg_rdata <= {13'h0000,
                                             state == vtadc_pkg::VTADC_ST_SETTLING,
                                             new_flag, result_valid};
            default:           reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

//--- tb/vtadc_afe.sv
// Analogue front-end model feeding one fixed word per selected source.
`timescale 1ns/1ps
`default_nettype none
module vtadc_afe (
   input  wire logic [2:0]  source_sel,
   input  wire logic        atten_buf_en,
   output logic      [15:0] filter_data
);
   // Voltage reads through only with its buffers on; a bad select gives a foreign word.
   assign filter_data = (source_sel == 3'h1 && atten_buf_en) ? 16'h5a01 :
                        (source_sel == 3'h2) ? 16'h5a02 :
                        (source_sel == 3'h4) ? 16'h5a04 : 16'ha5fe;
endmodule
`default_nettype wire

//--- tb/vtadc_top_bench.sv
// Bench for the auxiliary converter control: rates, settling, sources and ground switch.
`timescale 1ns/1ps
`default_nettype none
module vtadc_top_bench;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic [3:0]  reg_addr  = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   wire logic [15:0] reg_rdata, filter_data, result;
   wire logic [2:0]  source_sel;
   wire logic        atten_buf_en, gnd_direct_en, gnd_resistor_en, run_en, result_valid, result_strobe;
   int          fails     = 0;
   int          cmp_count = 0;
   int          cyc       = 0;
   logic [15:0] rd_val;
   // The last filter code is unlisted and must run at the fastest rate.
   int          per [6]   = '{40, 30, 20, 10, 5, 5};
   logic [15:0] code [6]  = '{16'hbf1d, 16'h961f, 16'h007f, 16'h0007, 16'h0000, 16'h1234};
   vtadc_top #(.PER_4HZ(40), .PER_10HZ(30), .PER_50HZ(20), .PER_1KHZ(10), .PER_8KHZ(5)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filter_data(filter_data), .source_sel(source_sel),
      .atten_buf_en(atten_buf_en), .gnd_direct_en(gnd_direct_en), .gnd_resistor_en(gnd_resistor_en),
      .run_en(run_en), .result(result), .result_valid(result_valid), .result_strobe(result_strobe));
   vtadc_afe afe (.source_sel(source_sel), .atten_buf_en(atten_buf_en), .filter_data(filter_data));
   // Clock and hang guard.
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
   // Waits for one result strobe, sampled away from the clock edge.
   task automatic wait_strobe();
      int n;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (result_strobe !== 1'b1 && n < 100);
      check({15'h0000, result_strobe}, 16'h0001);
   endtask
   // Counts strobes until the result is flagged settled.
   task automatic settle(input logic [15:0] n_exp);
      int k;
      k = 0;
      do begin
         wait_strobe();
         k++;
      end while (result_valid !== 1'b1 && k < 5);
      check(16'(k), n_exp);
   endtask
   task automatic scen_rates();
      realtime t0;
      for (int i = 0; i < 6; i++) begin
         wr(4'h2, code[i]);
         settle(code[i][15] ? 16'h0002 : 16'h0003);
         check(result, 16'h5a01);
         t0 = $realtime;
         wait_strobe();
         check(16'(int'(($realtime - t0) / 40.0)), 16'(per[i]));
      end
   endtask
   task automatic scen_source();
      int         src [4] = '{1, 2, 0, 3};
      logic [2:0] sel [4] = '{3'h2, 3'h4, 3'h1, 3'h1};
      for (int s = 0; s < 4; s++) begin
         wr(4'h0, 16'(src[s]));
         repeat (2) @(negedge sys_clk);
         check({13'h0000, source_sel}, {13'h0000, sel[s]});
         check({15'h0000, atten_buf_en}, {15'h0000, sel[s][0]});
         if (s < 3) begin
            settle(16'h0003);
            check(result, {13'h0b40, sel[s]});
         end
      end
   endtask
   task automatic scen_ground();
      for (int g = 0; g < 4; g++) begin
         wr(4'h0, {8'h00, g[1], 7'h00});
         wr(4'h1, {9'h000, g[0], 6'h01});
         repeat (2) @(negedge sys_clk);
         check({14'h0, gnd_direct_en, gnd_resistor_en}, {14'h0, g[1] & ~g[0], g[1] & g[0]});
      end
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(4'h2, rd_val);
      check(rd_val, 16'h0007);
      rd(4'h0, rd_val);
      check(rd_val, 16'h0000);
      wr(4'h1, 16'h0001);
      repeat (2) @(negedge sys_clk);
      check({15'h0000, run_en}, 16'h0001);
      scen_rates();
      scen_source();
      rd(4'h3, rd_val);
      check(rd_val, 16'h5a01);
      rd(4'h4, rd_val);
      check({15'h0000, rd_val[0]}, 16'h0001);
      scen_ground();
      wr(4'h1, 16'h0000);
      repeat (2) @(negedge sys_clk);
      check({15'h0000, run_en}, 16'h0000);
      check({15'h0000, result_valid}, 16'h0000);
      report_and_stop();
   end
endmodule
`default_nettype wire

//--- tb/vtadc_top_chk.sv
// Checker for the auxiliary converter control ports.
`timescale 1ns/1ps
`include "vtadc_defs.svh"
`default_nettype none
module vtadc_top_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] filter_data,
   input wire logic [2:0]  source_sel,
   input wire logic        atten_buf_en,
   input wire logic        gnd_direct_en,
   input wire logic        gnd_resistor_en,
   input wire logic        run_en,
   input wire logic [15:0] result,
   input wire logic        result_valid,
   input wire logic        result_strobe
);
   // All checks run on the system clock and rest during reset.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_one; rst_n && $past(rst_n) |-> $onehot(source_sel); endproperty
   a_one: assert property (p_one) else $error("source select not one-hot");
   property p_buf; $past(rst_n) && source_sel[0] && $past(source_sel[0]) |-> atten_buf_en; endproperty
   a_buf: assert property (p_buf) else $error("attenuator buffers off on voltage");
   property p_float; !(gnd_direct_en && gnd_resistor_en); endproperty
   a_float: assert property (p_float) else $error("both ground paths on");
   property p_gndoff; reg_wr && reg_addr == 4'h0 && !reg_wdata[7] |-> ##2 !gnd_direct_en && !gnd_resistor_en; endproperty
   a_gndoff: assert property (p_gndoff) else $error("ground switch not floating");
   property p_run; reg_wr && reg_addr == 4'h1 |-> ##2 run_en == $past(reg_wdata[0], 2); endproperty
   a_run: assert property (p_run) else $error("run enable not from mode write");
   property p_pulse; result_strobe |=> !result_strobe; endproperty
   a_pulse: assert property (p_pulse) else $error("result strobe longer than a cycle");
   property p_hold; $past(rst_n) && !result_strobe |-> $stable(result); endproperty
   a_hold: assert property (p_hold) else $error("result moved without strobe");
   property p_valid; $rose(result_valid) |-> result_strobe; endproperty
   a_valid: assert property (p_valid) else $error("valid rose off a strobe");
   property p_sta; $past(reg_rd) && $past(reg_addr) == 4'h4 |-> reg_rdata[0] == $past(result_valid); endproperty
   a_sta: assert property (p_sta) else $error("status valid bit wrong");
endmodule
bind vtadc_top vtadc_top_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filter_data(filter_data),
   .source_sel(source_sel), .atten_buf_en(atten_buf_en), .gnd_direct_en(gnd_direct_en),
   .gnd_resistor_en(gnd_resistor_en), .run_en(run_en), .result(result), .result_valid(result_valid),
   .result_strobe(result_strobe));
`default_nettype wire
